//--- rtl/ptb_lock.sv
`timescale 1ns/1ps
`default_nettype none
module ptb_lock (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Lock enable
  input wire logic lock_cfg,
  // Access events
  ptb_lock_if.lock lk
);
  ptb_pkg::ptb_lock_t state_reg;
  ptb_pkg::ptb_lock_t state_next;

  ////////////////////////////////////////////////////////////////////////
  // Grant only in open state or with lock disabled
  assign lk.grant = !lock_cfg || (state_reg == ptb_pkg::LK_OPEN);

  // Any access moves the sequence; wrong one restarts it
  always_comb begin
    state_next = state_reg;
    if (lk.acc) begin
      case (state_reg)
        ptb_pkg::LK_IDLE: begin
          if (lk.wr && lk.key_hit && lk.wdata == ptb_pkg::KEY_FIRST) begin
            state_next = ptb_pkg::LK_KEY1;
          end
        end
        ptb_pkg::LK_KEY1: begin
          if (lk.wr && lk.key_hit && lk.wdata == ptb_pkg::KEY_SECOND) begin
            state_next = ptb_pkg::LK_OPEN;
          end else begin
            state_next = ptb_pkg::LK_IDLE;
          end
        end
        ptb_pkg::LK_OPEN: begin
          // One access closes it, used or not
          state_next = ptb_pkg::LK_IDLE;
        end
        default: state_next = ptb_pkg::LK_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ptb_pkg::LK_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule
`default_nettype wire

//--- rtl/ptb_lock_if.sv
`timescale 1ns/1ps
`default_nettype none
// Access events from the bus slave to the lock unit
interface ptb_lock_if;
  logic acc;
  logic wr;
  logic key_hit;
  logic prot_hit;
  logic [15:0] wdata;
  logic grant;
  modport bus (output acc, wr, key_hit, prot_hit, wdata, input grant);
  modport lock (input acc, wr, key_hit, prot_hit, wdata, output grant);
endinterface
`default_nettype wire

//--- rtl/ptb_pkg.sv
package ptb_pkg;
  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_PERIOD = 8'h08;
  localparam logic [7:0] OFF_SECMP = 8'h0C;
  localparam logic [7:0] OFF_OUTCON = 8'h10;
  localparam logic [7:0] OFF_FLTA = 8'h14;
  localparam logic [7:0] OFF_FLTB = 8'h18;
  localparam logic [7:0] OFF_KEY = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_MASK = 8'h24;

  // Control register fields
  localparam int CTRL_EN_BIT = 15;
  localparam int CTRL_IDLE_BIT = 13;
  localparam int CTRL_POST_LSB = 4;
  localparam int CTRL_PRE_LSB = 2;
  localparam int CTRL_MODE_LSB = 0;
  localparam logic [15:0] CTRL_MASK = 16'hA0FF;
  localparam int DIR_BIT = 15;

  // Reset values and writable masks
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] OUTCON_RST = 16'h0000;
  localparam logic [15:0] OUTCON_MASK = 16'h0777;
  localparam logic [15:0] FLTA_RST = 16'h0007;
  localparam logic [15:0] FLTB_RST = 16'h0007;
  localparam logic [15:0] FLT_MASK = 16'h3F87;

  // Unlock keys
  localparam logic [15:0] KEY_FIRST = 16'hABCD;
  localparam logic [15:0] KEY_SECOND = 16'h4321;

  // Status bits: 0 period event, 1 special event, 2 lock violation
  localparam int STAT_W = 3;
  localparam int ST_PERIOD = 0;
  localparam int ST_SEVT = 1;
  localparam int ST_LOCKERR = 2;

  // Prescale tick counts in instruction cycles
  localparam logic [5:0] PRE_DIV1 = 6'h00;
  localparam logic [5:0] PRE_DIV4 = 6'h03;
  localparam logic [5:0] PRE_DIV16 = 6'h0F;
  localparam logic [5:0] PRE_DIV64 = 6'h3F;

  // Unlock sequence states
  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_KEY1 = 3'b010,
    LK_OPEN = 3'b100
  } ptb_lock_t;
endpackage

//--- rtl/ptb_prescale.sv
`timescale 1ns/1ps
`default_nettype none
module ptb_prescale (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [1:0] sel,
  // Count tick
  output logic tick
);
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [5:0] limit;

  ////////////////////////////////////////////////////////////////////////
  // Tick period 1, 4, 16 or 64 cycles
  always_comb begin
    case (sel)
      2'h0: limit = ptb_pkg::PRE_DIV1;
      2'h1: limit = ptb_pkg::PRE_DIV4;
      2'h2: limit = ptb_pkg::PRE_DIV16;
      default: limit = ptb_pkg::PRE_DIV64;
    endcase
  end

  assign tick = run && (cnt_reg >= limit);

  // Cleared while stopped so restart is aligned
  always_comb begin
    cnt_next = cnt_reg;
    if (!run || tick) begin
      cnt_next = 6'h00;
    end else begin
      cnt_next = cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

//--- rtl/ptb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Lock blocks output and fault control writes
// - Config bit one locks, zero disables lock
// - Protected write must directly follow keys
// - One unlock allows one protected write
// - Idle stop bit halts base in idle
// - Postscaler divides events by field plus one
// - Prescale codes give 1, 4, 16, 64 cycles
// - Count bit 15 reads direction, down high
// - Count bits 14-0 readable and writable
// - Period 15 bits, bit 15 reads zero
// - Compare 15-bit value against count
// - Trigger also needs matching direction bit
module ptb_top #(
  parameter int CW = 15
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System inputs
  input wire logic lock_cfg,
  input wire logic cpu_idle,
  // Event and control outputs
  output logic special_event,
  output logic period_event,
  output logic [15:0] output_pair_control,
  output logic [15:0] fault_a_control,
  output logic [15:0] fault_b_control,
  output logic irq
);
  ptb_lock_if lk ();

  logic [15:0] ctrl_reg, ctrl_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic dir_reg, dir_next;
  logic [CW-1:0] per_reg, per_next;
  logic [CW-1:0] cmp_reg, cmp_next;
  logic sdir_reg, sdir_next;
  logic [15:0] outcon_reg, outcon_next;
  logic [15:0] flta_reg, flta_next;
  logic [15:0] fltb_reg, fltb_next;
  logic [3:0] post_reg, post_next;
  logic [ptb_pkg::STAT_W-1:0] stat_reg, stat_next;
  logic [ptb_pkg::STAT_W-1:0] mask_reg, mask_next;
  logic [31:0] rd_reg, rd_next;
  logic sevt_reg, sevt_next;
  logic pev_reg, pev_next;
  logic idle_s1, idle_s2, lock_s1, lock_s2;

  logic acc, wr_acc, rd_acc, tick, run, at_top, at_zero, blocked, wrap;
  logic [15:0] cnt_wr, per_wr;
  logic [1:0] mode;
  logic [15:0] wd;
  logic [ptb_pkg::STAT_W-1:0] ev;

  // Merge a 16-bit write under byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [3:0] st,
                                          input logic [15:0] msk);
    logic [15:0] r;
    r = old;
    if (st[0]) r[7:0] = nw[7:0];
    if (st[1]) r[15:8] = nw[15:8];
    merge16 = (r & msk) | (old & ~msk);
  endfunction

  // Decode a known register offset
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ptb_pkg::OFF_CTRL) || (a == ptb_pkg::OFF_COUNT) ||
             (a == ptb_pkg::OFF_PERIOD) || (a == ptb_pkg::OFF_SECMP) ||
             (a == ptb_pkg::OFF_OUTCON) || (a == ptb_pkg::OFF_FLTA) ||
             (a == ptb_pkg::OFF_FLTB) || (a == ptb_pkg::OFF_KEY) ||
             (a == ptb_pkg::OFF_STATUS) || (a == ptb_pkg::OFF_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin level synchronisers; first stage read only by second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_s1 <= 1'b0;
      idle_s2 <= 1'b0;
      lock_s1 <= 1'b1;
      lock_s2 <= 1'b1;
    end else begin
      idle_s1 <= cpu_idle;
      idle_s2 <= idle_s1;
      lock_s1 <= lock_cfg;
      lock_s2 <= lock_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped(paddr);
  assign prdata = rd_reg;
  assign wd = pwdata[15:0];

  // Every completed access feeds the unlock sequencer
  assign lk.acc = acc;
  assign lk.wr = pwrite;
  assign lk.wdata = wd;
  assign lk.key_hit = (paddr == ptb_pkg::OFF_KEY);
  assign lk.prot_hit = (paddr == ptb_pkg::OFF_OUTCON) ||
                       (paddr == ptb_pkg::OFF_FLTA) ||
                       (paddr == ptb_pkg::OFF_FLTB);
  assign blocked = !lk.grant;

  ptb_lock u_lock (
    .clk(clk),
    .rst_n(rst_n),
    .lock_cfg(lock_s2),
    .lk(lk)
  );

  ////////////////////////////////////////////////////////////////////////
  // Time base clocking: enable, idle stop, prescale
  assign run = ctrl_reg[ptb_pkg::CTRL_EN_BIT] &&
               !(ctrl_reg[ptb_pkg::CTRL_IDLE_BIT] && idle_s2);
  assign mode = ctrl_reg[ptb_pkg::CTRL_MODE_LSB +: 2];

  ptb_prescale u_pre (
    .clk(clk),
    .rst_n(rst_n),
    .run(run),
    .sel(ctrl_reg[ptb_pkg::CTRL_PRE_LSB +: 2]),
    .tick(tick)
  );

  assign at_top = (cnt_reg >= per_reg);
  assign at_zero = (cnt_reg == '0);

  ////////////////////////////////////////////////////////////////////////
  // Counter, direction, events and postscaler
  always_comb begin
    cnt_next = cnt_reg;
    dir_next = dir_reg;
    post_next = post_reg;
    pev_next = 1'b0;
    sevt_next = 1'b0;
    wrap = 1'b0;
    if (tick) begin
      if (mode[1]) begin
        // Up/down modes turn at period and at zero
        if (!dir_reg && at_top) begin
          dir_next = 1'b1;
          cnt_next = cnt_reg - CW'(1);
        end else if (dir_reg && at_zero) begin
          dir_next = 1'b0;
          cnt_next = cnt_reg + CW'(1);
          wrap = 1'b1;
        end else begin
          cnt_next = dir_reg ? cnt_reg - CW'(1) : cnt_reg + CW'(1);
        end
      end else begin
        // Free-running and single-shot only count up
        dir_next = 1'b0;
        if (at_top) begin
          cnt_next = '0;
          wrap = 1'b1;
        end else begin
          cnt_next = cnt_reg + CW'(1);
        end
      end
      // Compare value and direction both must match
      if (cnt_reg == cmp_reg && sdir_reg == dir_reg) begin
        sevt_next = 1'b1;
      end
    end
    // Period events pass the postscaler; >= copes with a lowered field
    if (wrap) begin
      if (post_reg >= ctrl_reg[ptb_pkg::CTRL_POST_LSB +: 4]) begin
        post_next = 4'h0;
        pev_next = 1'b1;
      end else begin
        post_next = post_reg + 4'h1;
      end
    end
    if (wr_acc && paddr == ptb_pkg::OFF_COUNT) begin
      cnt_next = cnt_wr[CW-1:0];
    end
  end

  // Masked merges of count and period writes
  assign cnt_wr = merge16({1'b0, cnt_reg}, wd, pstrb, 16'h7FFF);
  assign per_wr = merge16({1'b0, per_reg}, wd, pstrb, 16'h7FFF);

  ////////////////////////////////////////////////////////////////////////
  // Software registers; protected ones gated by the lock
  always_comb begin
    ctrl_next = ctrl_reg;
    per_next = per_reg;
    cmp_next = cmp_reg;
    sdir_next = sdir_reg;
    outcon_next = outcon_reg;
    flta_next = flta_reg;
    fltb_next = fltb_reg;
    mask_next = mask_reg;
    if (tick && mode == 2'h1 && !mode[1] && at_top) begin
      ctrl_next[ptb_pkg::CTRL_EN_BIT] = 1'b0;
    end
    if (wr_acc) begin
      case (paddr)
        ptb_pkg::OFF_CTRL:
          ctrl_next = merge16(ctrl_reg, wd, pstrb, ptb_pkg::CTRL_MASK);
        ptb_pkg::OFF_PERIOD:
          per_next = per_wr[CW-1:0];
        ptb_pkg::OFF_SECMP: begin
          {sdir_next, cmp_next} = merge16({sdir_reg, cmp_reg}, wd, pstrb,
                                          16'hFFFF);
        end
        ptb_pkg::OFF_OUTCON: begin
          if (!blocked) begin
            outcon_next = merge16(outcon_reg, wd, pstrb,
                                  ptb_pkg::OUTCON_MASK);
          end
        end
        ptb_pkg::OFF_FLTA: begin
          if (!blocked) begin
            flta_next = merge16(flta_reg, wd, pstrb, ptb_pkg::FLT_MASK);
          end
        end
        ptb_pkg::OFF_FLTB: begin
          if (!blocked) begin
            fltb_next = merge16(fltb_reg, wd, pstrb, ptb_pkg::FLT_MASK);
          end
        end
        ptb_pkg::OFF_MASK:
          mask_next = pwdata[ptb_pkg::STAT_W-1:0];
        default: mask_next = mask_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky status: set wins over clear-on-read
  always_comb begin
    ev = '0;
    ev[ptb_pkg::ST_PERIOD] = pev_next;
    ev[ptb_pkg::ST_SEVT] = sevt_next;
    ev[ptb_pkg::ST_LOCKERR] = wr_acc && lk.prot_hit && blocked;
    stat_next = stat_reg;
    if (rd_acc && paddr == ptb_pkg::OFF_STATUS) begin
      stat_next = '0;
    end
    stat_next = stat_next | ev;
  end

  // Read mux, registered at the access edge
  always_comb begin
    rd_next = rd_reg;
    if (rd_acc) begin
      case (paddr)
        ptb_pkg::OFF_CTRL: rd_next = {16'h0000, ctrl_reg};
        ptb_pkg::OFF_COUNT:
          rd_next = {16'h0000, dir_reg, cnt_reg};
        ptb_pkg::OFF_PERIOD: rd_next = {17'h0, per_reg};
        ptb_pkg::OFF_SECMP: rd_next = {16'h0000, sdir_reg, cmp_reg};
        ptb_pkg::OFF_OUTCON: rd_next = {16'h0000, outcon_reg};
        ptb_pkg::OFF_FLTA: rd_next = {16'h0000, flta_reg};
        ptb_pkg::OFF_FLTB: rd_next = {16'h0000, fltb_reg};
        ptb_pkg::OFF_STATUS: rd_next = {29'h0, stat_reg};
        ptb_pkg::OFF_MASK: rd_next = {29'h0, mask_reg};
        default: rd_next = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers; fault controls reset to 7, the rest cleared
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= ptb_pkg::CTRL_RST;
      cnt_reg <= '0;
      dir_reg <= 1'b0;
      per_reg <= '0;
      cmp_reg <= '0;
      sdir_reg <= 1'b0;
      outcon_reg <= ptb_pkg::OUTCON_RST;
      flta_reg <= ptb_pkg::FLTA_RST;
      fltb_reg <= ptb_pkg::FLTB_RST;
      post_reg <= 4'h0;
      stat_reg <= '0;
      mask_reg <= '0;
      rd_reg <= 32'h00000000;
      sevt_reg <= 1'b0;
      pev_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      cnt_reg <= cnt_next;
      dir_reg <= dir_next;
      per_reg <= per_next;
      cmp_reg <= cmp_next;
      sdir_reg <= sdir_next;
      outcon_reg <= outcon_next;
      flta_reg <= flta_next;
      fltb_reg <= fltb_next;
      post_reg <= post_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rd_reg <= rd_next;
      sevt_reg <= sevt_next;
      pev_reg <= pev_next;
    end
  end

  // Outputs from flip-flops, except irq which ORs the masked status bits
  assign special_event = sevt_reg;
  assign period_event = pev_reg;
  assign output_pair_control = outcon_reg;
  assign fault_a_control = flta_reg;
  assign fault_b_control = fltb_reg;
  assign irq = |(stat_reg & mask_reg);
endmodule
`default_nettype wire

//--- testbench/ptb_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side of the event outputs: counts pulses and their spacing
module ptb_stage_model (
  // Clock
  input wire logic clk,
  // Event pulses
  input wire logic period_event,
  input wire logic special_event,
  // Observations
  output int pev_n,
  output int pev_gap,
  output int sev_n,
  output int sev_gap
);
  int now;
  int pt;
  int st;
  initial begin
    {now, pt, st, pev_n, pev_gap, sev_n, sev_gap} = '0;
  end
  // Gaps are in clock cycles, so any stray pulse shows as a short gap
  always @(posedge clk) begin
    now <= now + 1;
    if (period_event === 1'b1) begin
      pev_n <= pev_n + 1;
      pev_gap <= now - pt;
      pt <= now;
    end
    if (special_event === 1'b1) begin
      sev_n <= sev_n + 1;
      sev_gap <= now - st;
      st <= now;
    end
  end
endmodule
`default_nettype wire

//--- testbench/ptb_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ptb_top_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  // Outputs
  input wire logic [15:0] output_pair_control,
  input wire logic [15:0] fault_a_control,
  input wire logic [15:0] fault_b_control,
  input wire logic special_event,
  input wire logic period_event,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic acc;
  logic wr_acc;
  logic [15:0] wlo;
  logic [1:0] cause_reg;
  logic [1:0] cause_next;
  // Full low-half writes only; a register change from a partial-strobe write is flagged
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite && (pstrb[1:0] == 2'b11);
  assign wlo = pwdata[15:0];
  // Status may lag its cause by up to two cycles
  always_comb begin
    cause_next = {cause_reg[0], special_event || period_event || wr_acc};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= 2'b00;
    end else begin
      cause_reg <= cause_next;
    end
  end
  a_outcon_write: assert property ($changed(output_pair_control) |->
    $past(wr_acc) && $past(paddr) == ptb_pkg::OFF_OUTCON &&
    output_pair_control == ($past(wlo) & ptb_pkg::OUTCON_MASK))
    else $error("output pair control changed without a write");
  a_flta_write: assert property ($changed(fault_a_control) |->
    $past(wr_acc) && $past(paddr) == ptb_pkg::OFF_FLTA)
    else $error("fault a control changed without a write");
  a_fltb_write: assert property ($changed(fault_b_control) |->
    $past(wr_acc) && $past(paddr) == ptb_pkg::OFF_FLTB)
    else $error("fault b control changed without a write");
  a_reset_values: assert property ($rose(rst_n) |->
    fault_a_control == ptb_pkg::FLTA_RST && !irq &&
    fault_b_control == ptb_pkg::FLTB_RST && output_pair_control == 16'h0000)
    else $error("protected registers wrong after reset");
  a_slverr_map: assert property (acc && paddr > ptb_pkg::OFF_MASK |-> pslverr)
    else $error("unmapped access not flagged");
  a_slverr_phase: assert property (pslverr |-> acc)
    else $error("error flag outside access phase");
  a_irq_cause: assert property ($rose(irq) |-> (|cause_next) || (|cause_reg))
    else $error("interrupt rose without event or write");
  a_irq_clear: assert property ($fell(irq) |-> $past(acc))
    else $error("interrupt fell without an access");
endmodule
`default_nettype wire
bind ptb_top ptb_top_chk u_chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pslverr(pslverr), .output_pair_control(output_pair_control),
  .fault_a_control(fault_a_control), .fault_b_control(fault_b_control),
  .special_event(special_event), .period_event(period_event), .irq(irq)
);

//--- testbench/tb_pwm_time_base_write_lock.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_time_base_write_lock;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic lock_cfg = 1'b1;
  logic cpu_idle = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, sevt, pevt, irq, rd_seen;
  logic [15:0] opc, fac, fbc, v;
  logic [31:0] seed = 32'h0000000D;
  logic [31:0] x;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [7:0] a;
  int pev_n, pev_gap, sev_n, sev_gap, i, k;
  int fail_count = 0;
  int compares = 0;
  always #5 clk = ~clk;
  ptb_top #(.CW(15)) uut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lock_cfg(lock_cfg), .cpu_idle(cpu_idle), .special_event(sevt),
    .period_event(pevt), .output_pair_control(opc),
    .fault_a_control(fac), .fault_b_control(fbc), .irq(irq)
  );
  ptb_stage_model u_stage (
    .clk(clk), .period_event(pevt), .special_event(sevt), .pev_n(pev_n),
    .pev_gap(pev_gap), .sev_n(sev_n), .sev_gap(sev_gap)
  );
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] port(input int n);
    return (n == 0) ? opc : ((n == 1) ? fac : fbc);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] e);
    compares++;
    if (got !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  // One APB transfer, then an idle cycle so no strobe is set twice
  task automatic apb(input logic w, input logic [7:0] ad, input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    if (ad > ptb_pkg::OFF_MASK) check(pslverr, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, ad, 16'h0000);
  endtask
  // Stray read after key one (1) or key two (2)
  task automatic unlock(input int gap);
    apb(1'b1, ptb_pkg::OFF_KEY, ptb_pkg::KEY_FIRST);
    if (gap == 1) rd(ptb_pkg::OFF_CTRL, 32'h0, 32'h0);
    apb(1'b1, ptb_pkg::OFF_KEY, ptb_pkg::KEY_SECOND);
    if (gap == 2) rd(ptb_pkg::OFF_CTRL, 32'h0, 32'h0);
  endtask
  task automatic wait_pev(input int n);
    k = pev_n + n;
    while (pev_n < k) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Read data is registered, so it is judged one cycle after the access
  always @(posedge clk) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      check(prdata & msk_q[0], exp_q[0] & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    rd_seen <= psel && penable && !pwrite && pready;
  end
  initial begin
    #400000;
    fail_count++;
    $display("Error at %0t: timeout", $time);
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (i = 0; i < 4; i++) rd(8'(4 * i), 32'h0, 32'hFFFFFFFF);
    check(pev_n, 0);
    rd(8'h40, 32'h0, 32'hFFFFFFFF);
    $display("Test done: reset values");
    apb(1'b1, ptb_pkg::OFF_MASK, 16'h0004);
    apb(1'b1, ptb_pkg::OFF_OUTCON, 16'h0007);
    check(opc, ptb_pkg::OUTCON_RST);
    check(irq, 1'b1);
    rd(ptb_pkg::OFF_STATUS, 32'h4, 32'h4);
    check(irq, 1'b0);
    for (i = 0; i < 3; i++) begin
      a = ptb_pkg::OFF_OUTCON + 8'(4 * i);
      x = rnd() & ((i == 0) ? ptb_pkg::OUTCON_MASK : ptb_pkg::FLT_MASK);
      v = (x[15:0] & 16'hFFFB) | 16'h0002;
      unlock(1);
      apb(1'b1, a, v);
      unlock(2);
      apb(1'b1, a, v);
      check(port(i), (i == 0) ? 16'h0000 : 16'h0007);
      unlock(0);
      apb(1'b1, a, v);
      check(port(i), v);
      apb(1'b1, a, 16'h0000);
      check(port(i), v);
    end
    lock_cfg <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b1, ptb_pkg::OFF_FLTA, 16'h0080);
    check(fac, 16'h0080);
    lock_cfg <= 1'b1;
    $display("Test done: write lock");
    apb(1'b1, ptb_pkg::OFF_PERIOD, 16'hFFFF);
    rd(ptb_pkg::OFF_PERIOD, 32'h7FFF, 32'hFFFFFFFF);
    x = rnd();
    apb(1'b1, ptb_pkg::OFF_COUNT, x[15:0] | 16'h8000);
    rd(ptb_pkg::OFF_COUNT, {17'h0, x[14:0]}, 32'hFFFFFFFF);
    apb(1'b1, ptb_pkg::OFF_COUNT, 16'h0000);
    apb(1'b1, ptb_pkg::OFF_PERIOD, 16'h0003);
    // Every prescale code; the last pass takes the widest postscale
    for (i = 0; i < 4; i++) begin
      x = rnd();
      if (i == 3) x[3:0] = 4'hF;
      apb(1'b1, ptb_pkg::OFF_CTRL, {8'h80, x[3:0], 2'(i), 2'b00});
      wait_pev(3);
      check(pev_gap, 4 * (4 ** i) * (x[3:0] + 1));
      apb(1'b1, ptb_pkg::OFF_CTRL, 16'h0000);
    end
    $display("Test done: prescale and postscale");
    apb(1'b1, ptb_pkg::OFF_SECMP, 16'h0002);
    apb(1'b1, ptb_pkg::OFF_CTRL, 16'h8000);
    wait_pev(3);
    check(sev_gap, 4);
    apb(1'b1, ptb_pkg::OFF_SECMP, 16'h8002);
    wait_pev(1);
    i = sev_n;
    wait_pev(3);
    check(sev_n, i);
    // Up/down with period 3: six cycles, one down-count match each
    apb(1'b1, ptb_pkg::OFF_CTRL, 16'h8002);
    wait_pev(3);
    check(sev_gap, 6);
    check(pev_gap, 6);
    cpu_idle <= 1'b1;
    apb(1'b1, ptb_pkg::OFF_CTRL, 16'hA000);
    // Let a pulse launched at the write edge reach the model
    @(posedge clk);
    i = pev_n;
    repeat (40) @(posedge clk);
    check(pev_n, i);
    apb(1'b1, ptb_pkg::OFF_CTRL, 16'h8000);
    wait_pev(3);
    check(pev_gap, 4);
    apb(1'b1, ptb_pkg::OFF_CTRL, 16'h0000);
    // Single shot stops itself at the first period
    apb(1'b1, ptb_pkg::OFF_CTRL, 16'h8001);
    wait_pev(1);
    rd(ptb_pkg::OFF_CTRL, 32'h0001, 32'hFFFFFFFF);
    $display("Test done: events and idle");
    // Lock errors and both events are pending here
    apb(1'b1, ptb_pkg::OFF_MASK, 16'h0000);
    check(irq, 1'b0);
    apb(1'b1, ptb_pkg::OFF_MASK, 16'h0003);
    check(irq, 1'b1);
    rd(ptb_pkg::OFF_STATUS, 32'h7, 32'h7);
    check(irq, 1'b0);
    $display("Test done: interrupt");
    print_verdict();
  end
endmodule
`default_nettype wire
